// ### hdl/core_code_stepper.sv
// Paced stepper that walks the applied core voltage code toward its target.
`timescale 1ns/1ps
`include "power_rail_map.svh"

module core_code_stepper
    import power_rail_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int SLOWEST_STEP_CYCLES = `SLOWEST_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic load_default_i,
    input wire core_code_t default_code_i,
    input wire logic run_i,
    input wire core_code_t target_i,
    input wire logic [2:0] slew_i,
    // Status
    output core_code_t code_o,
    output logic reached_o
);

    // ========================================================================
    // Elaboration check
    if (SLOWEST_STEP_CYCLES < 64 || SLOWEST_STEP_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
        $error("core_code_stepper: step cycle count out of range");
    end

    step_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    core_code_t code_q;
    logic [CNT_W-1:0] interval;
    slew_sel_t slew;

    // Each faster rate doubles, so the interval halves per code.
    assign slew = slew_sel_t'(slew_i);
    assign interval = CNT_W'(SLOWEST_STEP_CYCLES) >> slew_i;
    assign code_o = code_q;
    assign reached_o = run_i && (code_q == target_i);

    // Pacing and one-code stepping; a default load overrides any transition.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= STEP_IDLE;
            cnt_q <= '0;
            code_q <= `CORE_CODE_PIN_LOW;
        end else if (load_default_i) begin
            state_q <= STEP_IDLE;
            cnt_q <= '0;
            code_q <= default_code_i;
        end else begin
            unique case (state_q)
                STEP_IDLE: begin
                    if (run_i && code_q != target_i) begin
                        if (slew == SLEW_IMMEDIATE) begin
                            code_q <= target_i;
                        end else begin
                            state_q <= STEP_PACE;
                            cnt_q <= interval - CNT_W'(1);
                        end
                    end
                end
                STEP_PACE: begin
                    if (!run_i) begin
                        state_q <= STEP_IDLE; // Abort holds the present code.
                    end else if (cnt_q != '0) begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end else begin
                        state_q <= STEP_IDLE;
                        if (code_q < target_i) begin
                            code_q <= code_q + 5'h01;
                        end else if (code_q > target_i) begin
                            code_q <= code_q - 5'h01;
                        end
                    end
                end
            endcase
        end
    end

endmodule : core_code_stepper

// ### hdl/power_rail_control.sv
// Control registers for three buck converters and two linear regulators.
`timescale 1ns/1ps
`include "power_rail_map.svh"

module power_rail_control
    import power_rail_pkg::*;
#(
    parameter int SLOWEST_STEP_CYCLES = `SLOWEST_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port from the serial engine
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Slew select from the slew register
    input wire logic [2:0] core_slew_select_i,
    // Device pins and internal monitors (asynchronous)
    input wire logic first_buck_enable_pin_i,
    input wire logic second_buck_enable_pin_i,
    input wire logic core_buck_enable_pin_i,
    input wire logic linear_reg_enable_pin_i,
    input wire logic core_default_select_pin_i,
    input wire logic undervoltage_lockout_i,
    input wire logic warm_reset_pin_n_i,
    input wire logic power_on_reset_output_i,
    input wire logic backup_clock_supply_low_i,
    // Supply enables
    output logic first_buck_on_o,
    output logic second_buck_on_o,
    output logic core_buck_on_o,
    output logic first_linear_reg_on_o,
    output logic second_linear_reg_on_o,
    // Converter modes
    output logic [1:0] first_buck_phase_o,
    output logic [1:0] second_buck_phase_o,
    output logic [1:0] core_buck_phase_o,
    output logic low_ripple_o,
    output logic first_buck_forced_fixed_frequency_o,
    output logic second_buck_forced_fixed_frequency_o,
    output logic core_buck_forced_fixed_frequency_o,
    // Output discharge
    output logic first_buck_discharge_o,
    output logic second_buck_discharge_o,
    output logic core_buck_discharge_o,
    // Core voltage
    output logic core_source_pin_o,
    output logic [4:0] core_code_o,
    output logic dvt_done_o
);

    // ========================================================================
    // Pin synchronisers
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_meta_q;
    logic [NSYNC-1:0] pin_sync_q;
    logic [NSYNC-1:0] pin_raw;

    assign pin_raw = {first_buck_enable_pin_i, second_buck_enable_pin_i, core_buck_enable_pin_i,
                      linear_reg_enable_pin_i, core_default_select_pin_i, undervoltage_lockout_i,
                      warm_reset_pin_n_i, power_on_reset_output_i, backup_clock_supply_low_i};

    // Two flops per pin; idle levels chosen so nothing fires before the pins settle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= 9'h004;
            pin_sync_q <= 9'h004;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    logic pin_first_en;
    logic pin_second_en;
    logic pin_core_en;
    logic pin_linear_en;
    logic pin_def_sel;
    logic undervoltage_lockout;
    logic warm_reset_n;
    logic por_active;
    logic backup_low;

    assign {pin_first_en, pin_second_en, pin_core_en, pin_linear_en, pin_def_sel, undervoltage_lockout,
            warm_reset_n, por_active, backup_low} = pin_sync_q;

    // ========================================================================
    // Start-up settle counter: the pin-dependent core default is caught only
    // after the synchronisers hold real pin levels.
    logic [1:0] settle_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_q <= 2'h0;
        end else if (settle_q != `PIN_SETTLE_CYCLES) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // ========================================================================
    // Helpers
    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] offset, input logic wr);
        wr_hit = wr && (addr == offset);
    endfunction : wr_hit

    // Phase field to delay in quarter switching cycles; 10 is half a cycle.
    function automatic logic [1:0] phase_quarters(input logic [1:0] field);
        phase_quarters = field;
    endfunction : phase_quarters

    logic wr_supply;
    logic wr_phase;
    logic wr_dvm;
    logic wr_core;

    assign wr_supply = wr_hit(reg_addr_i, `SUPPLY_ENABLE_OFFSET, reg_wr_i);
    assign wr_phase = wr_hit(reg_addr_i, `PHASE_MODE_OFFSET, reg_wr_i);
    assign wr_dvm = wr_hit(reg_addr_i, `DVM_DISCHARGE_OFFSET, reg_wr_i);
    assign wr_core = wr_hit(reg_addr_i, `CORE_CODE_OFFSET, reg_wr_i);

    // ========================================================================
    // Supply enable register, bits 5:1 held.
    logic [5:1] supply_enable_control_q;
    logic [5:1] pin_low_force;

    // The shared regulator pin drives both linear regulator bits.
    assign pin_low_force = {~pin_first_en, ~pin_second_en, ~pin_core_en, ~pin_linear_en,
                            ~pin_linear_en};

    // Lockout and a low pin both force ones and win over a host write.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_enable_control_q <= 5'(`SUPPLY_ENABLE_RESET >> 1);
        end else if (undervoltage_lockout) begin
            supply_enable_control_q <= 5'(`SUPPLY_ENABLE_RESET >> 1);
        end else begin
            for (int b = 1; b <= 5; b++) begin
                if (pin_low_force[b]) begin
                    supply_enable_control_q[b] <= 1'b1;
                end else if (wr_supply) begin
                    supply_enable_control_q[b] <= reg_wdata_i[b];
                end
            end
        end
    end

    logic first_on;
    logic core_on;

    assign first_on = supply_enable_control_q[`EN_FIRST_BUCK_BIT] & pin_first_en;
    assign core_on = supply_enable_control_q[`EN_CORE_BUCK_BIT] & pin_core_en;

    // ========================================================================
    // Phase and mode register.
    logic [7:0] converter_phase_mode_control_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_phase_mode_control_q <= `PHASE_MODE_RESET;
        end else if (undervoltage_lockout) begin
            converter_phase_mode_control_q <= `PHASE_MODE_RESET;
        end else if (wr_phase) begin
            converter_phase_mode_control_q <= reg_wdata_i;
        end
    end

    // ========================================================================
    // Transition start, source select and discharge register.
    logic dvt_start_q;
    logic core_adj_q;
    logic [2:0] discharge_q;
    logic reached;

    // A host write of one in the same cycle as completion keeps the bit set.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dvt_start_q <= 1'b0;
        end else if (undervoltage_lockout) begin
            dvt_start_q <= 1'b0;
        end else if (wr_dvm && reg_wdata_i[`DVT_START_BIT]) begin
            dvt_start_q <= 1'b1;
        end else if (reached) begin
            dvt_start_q <= 1'b0;
        end else if (wr_dvm) begin
            dvt_start_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_adj_q <= 1'(`DVM_DISCHARGE_RESET >> `CORE_ADJ_BIT);
            discharge_q <= 3'h0;
        end else if (undervoltage_lockout) begin
            core_adj_q <= 1'(`DVM_DISCHARGE_RESET >> `CORE_ADJ_BIT);
            discharge_q <= 3'h0;
        end else if (wr_dvm) begin
            core_adj_q <= reg_wdata_i[`CORE_ADJ_BIT];
            discharge_q <= reg_wdata_i[`DIS_SECOND_BIT:`DIS_CORE_BIT];
        end
    end

    // ========================================================================
    // Core voltage code register (target of a transition).
    core_code_t core_voltage_code_q;
    core_code_t core_default;
    logic core_reset_event;

    assign core_default = pin_def_sel ? `CORE_CODE_PIN_HIGH : `CORE_CODE_PIN_LOW;
    assign core_reset_event = undervoltage_lockout || (!first_on && !core_on) || !warm_reset_n || por_active ||
                              backup_low || (settle_q != `PIN_SETTLE_CYCLES);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_voltage_code_q <= `CORE_CODE_PIN_LOW;
        end else if (core_reset_event) begin
            core_voltage_code_q <= core_default;
        end else if (wr_core) begin
            core_voltage_code_q <= reg_wdata_i[4:0];
        end
    end

    // ========================================================================
    // Applied code walks to the target only while the start bit is set.
    core_code_t applied_code;

    core_code_stepper #(
        .CNT_W(16),
        .SLOWEST_STEP_CYCLES(SLOWEST_STEP_CYCLES)
    ) u_stepper (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_default_i(core_reset_event),
        .default_code_i(core_default),
        .run_i(dvt_start_q),
        .target_i(core_voltage_code_q),
        .slew_i(core_slew_select_i),
        .code_o(applied_code),
        .reached_o(reached)
    );

    // ========================================================================
    // Registered outputs.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_buck_on_o <= 1'b0;
            second_buck_on_o <= 1'b0;
            core_buck_on_o <= 1'b0;
            first_linear_reg_on_o <= 1'b0;
            second_linear_reg_on_o <= 1'b0;
        end else begin
            first_buck_on_o <= first_on;
            second_buck_on_o <= supply_enable_control_q[`EN_SECOND_BUCK_BIT] & pin_second_en;
            core_buck_on_o <= core_on;
            first_linear_reg_on_o <= supply_enable_control_q[`EN_FIRST_LINEAR_BIT] & pin_linear_en;
            second_linear_reg_on_o <= supply_enable_control_q[`EN_SECOND_LINEAR_BIT] & pin_linear_en;
        end
    end

    // Mode outputs; the first converter is the phase reference.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_buck_phase_o <= 2'h0;
            second_buck_phase_o <= 2'h0;
            core_buck_phase_o <= 2'h0;
            low_ripple_o <= 1'b0;
            first_buck_forced_fixed_frequency_o <= 1'b0;
            second_buck_forced_fixed_frequency_o <= 1'b0;
            core_buck_forced_fixed_frequency_o <= 1'b0;
        end else begin
            first_buck_phase_o <= 2'h0;
            second_buck_phase_o <= phase_quarters(
                converter_phase_mode_control_q[`SECOND_PHASE_HI:`SECOND_PHASE_LO]);
            core_buck_phase_o <= phase_quarters(
                converter_phase_mode_control_q[`CORE_PHASE_HI:`CORE_PHASE_LO]);
            low_ripple_o <= converter_phase_mode_control_q[`LOW_RIPPLE_BIT];
            first_buck_forced_fixed_frequency_o <= converter_phase_mode_control_q[`FORCED_FIXED_FREQUENCY_FIRST_BIT];
            second_buck_forced_fixed_frequency_o <= converter_phase_mode_control_q[`FORCED_FIXED_FREQUENCY_SECOND_BIT];
            core_buck_forced_fixed_frequency_o <= converter_phase_mode_control_q[`FORCED_FIXED_FREQUENCY_CORE_BIT];
        end
    end

    // Discharge only acts while the converter is off.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_buck_discharge_o <= 1'b0;
            second_buck_discharge_o <= 1'b0;
            core_buck_discharge_o <= 1'b0;
        end else begin
            first_buck_discharge_o <= discharge_q[`DIS_FIRST_BIT] & ~first_on;
            second_buck_discharge_o <= discharge_q[`DIS_SECOND_BIT] &
                ~(supply_enable_control_q[`EN_SECOND_BUCK_BIT] & pin_second_en);
            core_buck_discharge_o <= discharge_q[`DIS_CORE_BIT] & ~core_on;
        end
    end

    // Core source, applied code and a done pulse masked by lockout, all registered.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_source_pin_o <= 1'b1;
            core_code_o <= `CORE_CODE_PIN_LOW;
            dvt_done_o <= 1'b0;
        end else begin
            core_source_pin_o <= core_adj_q;
            core_code_o <= applied_code;
            dvt_done_o <= reached && !undervoltage_lockout;
        end
    end

    // ========================================================================
    // Read path; unmapped offsets read zero, undefined bits read zero except enable bits 7:6 and 0, which read one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `SUPPLY_ENABLE_OFFSET: reg_rdata_o <= {2'h3, supply_enable_control_q, 1'b1};
                `PHASE_MODE_OFFSET: reg_rdata_o <= converter_phase_mode_control_q;
                `DVM_DISCHARGE_OFFSET: reg_rdata_o <= {dvt_start_q, core_adj_q, 3'h0, discharge_q};
                `CORE_CODE_OFFSET: reg_rdata_o <= {3'h0, core_voltage_code_q};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule : power_rail_control

// ### hdl/power_rail_map.svh
// Register offsets, field positions, reset values and timing counts of the power rail control block.
// ============================================================================
`ifndef POWER_RAIL_MAP_SVH
`define POWER_RAIL_MAP_SVH

// ============================================================================
// Register offsets
`define SUPPLY_ENABLE_OFFSET 8'h03
`define PHASE_MODE_OFFSET 8'h04
`define DVM_DISCHARGE_OFFSET 8'h05
`define CORE_CODE_OFFSET 8'h06

// ============================================================================
// Reset values
`define SUPPLY_ENABLE_RESET 8'hff
`define PHASE_MODE_RESET 8'hb0
`define DVM_DISCHARGE_RESET 8'h40
`define CORE_CODE_PIN_LOW 5'h14
`define CORE_CODE_PIN_HIGH 5'h1e

// ============================================================================
// Field positions
`define EN_FIRST_BUCK_BIT 5
`define EN_SECOND_BUCK_BIT 4
`define EN_CORE_BUCK_BIT 3
`define EN_SECOND_LINEAR_BIT 2
`define EN_FIRST_LINEAR_BIT 1
`define SECOND_PHASE_HI 7
`define SECOND_PHASE_LO 6
`define CORE_PHASE_HI 5
`define CORE_PHASE_LO 4
`define LOW_RIPPLE_BIT 3
`define FORCED_FIXED_FREQUENCY_SECOND_BIT 2
`define FORCED_FIXED_FREQUENCY_FIRST_BIT 1
`define FORCED_FIXED_FREQUENCY_CORE_BIT 0
`define DVT_START_BIT 7
`define CORE_ADJ_BIT 6
`define DIS_SECOND_BIT 2
`define DIS_FIRST_BIT 1
`define DIS_CORE_BIT 0

// ============================================================================
// Timing: one 25 mV code step at the slowest rate of 150 uV/us.
`define CLK_PERIOD_NS 5
`define CORE_STEP_UV 25000
`define SLOWEST_RATE_UV_PER_US 150
`define SLOWEST_STEP_NS (`CORE_STEP_UV * 1000 / `SLOWEST_RATE_UV_PER_US)
`define SLOWEST_STEP_CYCLES (`SLOWEST_STEP_NS / `CLK_PERIOD_NS)
`define PIN_SETTLE_CYCLES 2'h3

`endif

// ### hdl/power_rail_pkg.sv
// Types shared by the power rail control block.
package power_rail_pkg;

    // Slew selection codes, slowest first; the top code jumps at once.
    typedef enum logic [2:0] {
        SLEW_0P15 = 3'h0,
        SLEW_0P3 = 3'h1,
        SLEW_0P6 = 3'h2,
        SLEW_1P2 = 3'h3,
        SLEW_2P4 = 3'h4,
        SLEW_4P8 = 3'h5,
        SLEW_9P6 = 3'h6,
        SLEW_IMMEDIATE = 3'h7
    } slew_sel_t;

    // Stepper states.
    typedef enum logic [0:0] {
        STEP_IDLE = 1'b0,
        STEP_PACE = 1'b1
    } step_state_t;

    // Five-bit core voltage code.
    typedef logic [4:0] core_code_t;

endpackage : power_rail_pkg

// ### tb/rail_monitor.sv
// Concurrent checks on the ports of the power rail control block.
`timescale 1ns/1ps
module rail_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port and pins
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic first_buck_enable_pin_i,
    input wire logic linear_reg_enable_pin_i,
    input wire logic undervoltage_lockout_i,
    // Outputs under watch
    input wire logic first_buck_on_o,
    input wire logic second_linear_reg_on_o,
    input wire logic core_buck_on_o,
    input wire logic [1:0] first_buck_phase_o,
    input wire logic [1:0] second_buck_phase_o,
    input wire logic [1:0] core_buck_phase_o,
    input wire logic low_ripple_o,
    input wire logic first_buck_forced_fixed_frequency_o,
    input wire logic second_buck_forced_fixed_frequency_o,
    input wire logic core_buck_forced_fixed_frequency_o,
    input wire logic core_buck_discharge_o,
    input wire logic core_source_pin_o,
    input wire logic dvt_done_o
);
    // ========================================================================
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Pins pass two sync flops and an output flop, hence depth three.
    supply_first_a: assert property (first_buck_on_o |-> $past(first_buck_enable_pin_i, 3))
        else $error("first buck on without its pin");
    supply_linear_a: assert property (second_linear_reg_on_o |-> $past(linear_reg_enable_pin_i, 3))
        else $error("linear regulator on without its pin");
    first_phase_a: assert property (first_buck_phase_o == 2'h0)
        else $error("first buck phase not zero");
    mode_follow_a: assert property (reg_wr_i && reg_addr_i == 8'h04 && !$past(undervoltage_lockout_i, 2)
        |-> ##2 {second_buck_phase_o, core_buck_phase_o, low_ripple_o, second_buck_forced_fixed_frequency_o,
        first_buck_forced_fixed_frequency_o, core_buck_forced_fixed_frequency_o} == $past(reg_wdata_i, 2))
        else $error("mode outputs do not follow write");
    core_source_a: assert property (reg_wr_i && reg_addr_i == 8'h05 && !$past(undervoltage_lockout_i, 2)
        |-> ##2 core_source_pin_o == $past(reg_wdata_i[6], 2)) else $error("core source does not follow write");
    unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < 8'h03 || reg_addr_i > 8'h06)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    code_spare_a: assert property (reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("core code spare bits not zero");
    done_pulse_a: assert property (dvt_done_o |=> !dvt_done_o)
        else $error("done longer than one cycle");
    discharge_off_a: assert property (core_buck_discharge_o && $past(core_buck_discharge_o)
        |-> !$past(core_buck_on_o)) else $error("discharge while converter on");
    // Main scenarios.
    dvt_c: cover property (dvt_done_o);
    mode_c: cover property (reg_wr_i && reg_addr_i == 8'h04);
    lock_c: cover property ($rose(undervoltage_lockout_i));
endmodule : rail_monitor

bind power_rail_control rail_monitor rail_monitor_i (.*);

// ### tb/reg_host.sv
// Host model driving the parallel register port of the block.
`timescale 1ns/1ps
module reg_host (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] reg_wdata_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0,
    input wire logic [7:0] reg_rdata_i
);
    // One-cycle write strobe; data is inverted after release so stale values never pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clk_i);
        #1 reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr
    // Read data is registered at the taking edge, so it is picked up just after it.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i);
        #1 reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clk_i);
        #1 reg_rd_o = 1'b0;
        q = reg_rdata_i;
    endtask : rd
endmodule : reg_host

// ### tb/testbench.sv
// Self-checking bench for the power rail control registers.
`timescale 1ns/1ps
module testbench;
    // ========================================================================
    // Signals; the long slew count is cut to 64 cycles.
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, reg_rd_i;
    logic first_buck_enable_pin_i = 1'b1, linear_reg_enable_pin_i = 1'b1, core_default_select_pin_i = 1'b0;
    logic undervoltage_lockout_i = 1'b0, warm_reset_pin_n_i = 1'b1;
    logic second_buck_enable_pin_i = 1'b1, core_buck_enable_pin_i = 1'b1;
    logic power_on_reset_output_i = 1'b0, backup_clock_supply_low_i = 1'b0;
    logic [2:0] core_slew_select_i = 3'h5;
    logic first_buck_on_o, second_buck_on_o, core_buck_on_o, first_linear_reg_on_o, second_linear_reg_on_o;
    logic [1:0] first_buck_phase_o, second_buck_phase_o, core_buck_phase_o;
    logic low_ripple_o, first_buck_forced_fixed_frequency_o;
    logic second_buck_forced_fixed_frequency_o, core_buck_forced_fixed_frequency_o;
    logic first_buck_discharge_o, second_buck_discharge_o, core_buck_discharge_o, core_source_pin_o, dvt_done_o;
    logic [4:0] core_code_o;
    int fail_count = 0, tests_run = 0;
    power_rail_control #(.SLOWEST_STEP_CYCLES(64)) power_rail_control_i (.*);
    reg_host reg_host_i (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
    // 200 MHz clock.
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // ========================================================================
    // Helpers.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        reg_host_i.rd(a, q);
        chk(n, e, q);
    endtask : rd_chk
    // Every wait ends just after an edge, where the bench drives.
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // The whole sequence needs well under a tenth of this span.
    initial begin
        #200000;
        fail_count++;
        finish_test;
    end
    // ========================================================================
    // Test sequence.
    initial begin
        int i;
        logic [7:0] q;
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        step(4);
        rd_chk("enables", 8'h03, 8'hff);
        rd_chk("phase_mode", 8'h04, 8'hb0);
        rd_chk("dvt_discharge", 8'h05, 8'h40);
        rd_chk("core_code", 8'h06, 8'h14);
        rd_chk("unmapped", 8'h07, 8'h00);
        $display("test reset_values done");
        for (i = 0; i < 4; i++) begin
            q = {i[1:0], ~i[1:0], i[0], ~i[0], i[1], 1'b1};
            reg_host_i.wr(8'h04, q);
            step(2);
            chk("modes", q, {second_buck_phase_o, core_buck_phase_o, low_ripple_o, second_buck_forced_fixed_frequency_o,
                first_buck_forced_fixed_frequency_o, core_buck_forced_fixed_frequency_o});
            rd_chk("phase_read", 8'h04, q);
        end
        $display("test modes done");
        reg_host_i.wr(8'h03, 8'h00);
        reg_host_i.wr(8'h05, 8'h07);
        step(4);
        q = {3'h0, first_buck_on_o, second_buck_on_o, core_buck_on_o, second_linear_reg_on_o, first_linear_reg_on_o};
        chk("supplies_off", 8'h00, q);
        rd_chk("enables_written", 8'h03, 8'hc1);
        chk("discharge_on", 8'h07, {5'h0, second_buck_discharge_o, first_buck_discharge_o, core_buck_discharge_o});
        chk("source_reg", 8'h00, {7'h0, core_source_pin_o});
        first_buck_enable_pin_i = 1'b0;
        linear_reg_enable_pin_i = 1'b0;
        step(5);
        rd_chk("enables_forced", 8'h03, 8'he7);
        first_buck_enable_pin_i = 1'b1;
        linear_reg_enable_pin_i = 1'b1;
        step(5);
        q = {3'h0, first_buck_on_o, second_buck_on_o, core_buck_on_o, second_linear_reg_on_o, first_linear_reg_on_o};
        chk("supplies_back", 8'h13, q);
        chk("discharge_off", 8'h05, {5'h0, second_buck_discharge_o, first_buck_discharge_o, core_buck_discharge_o});
        undervoltage_lockout_i = 1'b1;
        step(5);
        undervoltage_lockout_i = 1'b0;
        step(5);
        rd_chk("enables_lockout", 8'h03, 8'hff);
        rd_chk("ctrl2_lockout", 8'h05, 8'h40);
        $display("test enables done");
        reg_host_i.wr(8'h06, 8'h17);
        reg_host_i.wr(8'h05, 8'hc0);
        for (i = 0; i < 200 && dvt_done_o !== 1'b1; i++) step(1);
        chk("paced", 8'h01, {7'h0, i >= 9 && i < 30});
        chk("code_reached", 8'h17, {3'h0, core_code_o});
        rd_chk("start_cleared", 8'h05, 8'h40);
        reg_host_i.wr(8'h06, 8'h10);
        step(20);
        chk("code_held", 8'h17, {3'h0, core_code_o});
        warm_reset_pin_n_i = 1'b0;
        step(5);
        warm_reset_pin_n_i = 1'b1;
        step(5);
        chk("code_warm_reset", 8'h14, {3'h0, core_code_o});
        reg_host_i.wr(8'h06, 8'h08);
        power_on_reset_output_i = 1'b1;
        step(5);
        power_on_reset_output_i = 1'b0;
        step(5);
        rd_chk("code_por", 8'h06, 8'h14);
        core_default_select_pin_i = 1'b1;
        undervoltage_lockout_i = 1'b1;
        step(5);
        undervoltage_lockout_i = 1'b0;
        step(5);
        rd_chk("code_pin_high", 8'h06, 8'h1e);
        $display("test core_voltage done");
        finish_test;
    end
endmodule : testbench
